// ===== core/cds_pkg.sv
package cds_pkg;
  localparam int          INSN_W       = 12;
  localparam int          DATA_W       = 8;
  localparam int          ADDR_W       = 5;
  localparam int          DEST_BIT     = 5;
  localparam int          OPC_LSB      = 6;
  localparam logic [5:0]  OPC_COMPL    = 6'h09; // 0010 01
  localparam logic [5:0]  OPC_MINUS    = 6'h03; // 0000 11
  localparam logic [5:0]  OPC_MINUS_SK = 6'h0b; // 0010 11
  localparam logic [7:0]  W_RESET      = 8'h00;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [7:0]  ONE_BYTE     = 8'h01;

  typedef enum logic [2:0] {
    OP_NONE   = 3'b001,
    OP_COMPL  = 3'b010,
    OP_MINUS  = 3'b100
  } op_class_e;

  typedef enum logic [1:0] {
    ST_RUN    = 2'b01,
    ST_FLUSH  = 2'b10
  } exec_state_e;
endpackage

// ===== core/complement_decrement_skip_exec.sv
`timescale 1ns/100ps
`default_nettype none
module complement_decrement_skip_exec (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              insn_valid,
  input  wire logic [11:0]       insn,
  input  wire logic [7:0]        file_rdata,
  output logic [4:0]             file_addr,
  output logic                   file_we,
  output logic [7:0]             file_wdata,
  output logic [7:0]             w_out,
  output logic                   zero_out,
  output logic                   zero_we,
  output logic                   flush,
  output logic                   busy,
  output logic                   insn_taken
);
  import cds_pkg::*;

  op_class_e   op_class;
  logic        is_skip;
  logic        dest_file;
  logic [4:0]  addr;

  op_decode u_dec (
    .insn      (insn),
    .op_class  (op_class),
    .is_skip   (is_skip),
    .dest_file (dest_file),
    .addr      (addr)
  );

  exec_state_e state_r, state_nxt;
  logic [7:0]  w_r, w_nxt;
  logic        zero_r, zero_nxt;
  logic        file_we_r, file_we_nxt;
  logic [7:0]  wdata_r, wdata_nxt;
  logic        zero_we_r, zero_we_nxt;
  logic [7:0]  result;
  logic        exec;

  function automatic logic [7:0] minus_one(input logic [7:0] v);
    minus_one = v - ONE_BYTE;
  endfunction

  // the flush cycle eats the word that the fetch stage already holds
  assign exec = insn_valid && (state_r == ST_RUN) && (op_class != OP_NONE);

  // write-back lands one cycle late at the address read the cycle before,
  // so a back-to-back reader of the same register still sees the old value
  assign file_addr  = addr;
  assign insn_taken = exec;
  assign busy       = (state_r == ST_FLUSH);
  assign flush      = (state_r == ST_FLUSH);

  always_comb begin
    result = (op_class == OP_COMPL) ? ~file_rdata : minus_one(file_rdata);
  end

  always_comb begin
    state_nxt   = state_r;
    w_nxt       = w_r;
    zero_nxt    = zero_r;
    file_we_nxt = 1'b0;
    wdata_nxt   = wdata_r;
    zero_we_nxt = 1'b0;
    case (state_r)
      ST_RUN: begin
        if (exec) begin
          if (dest_file) begin
            file_we_nxt = 1'b1;
            wdata_nxt   = result;
          end else begin
            w_nxt = result;
          end
          // the skip variant leaves the flag alone
          if (!is_skip) begin
            zero_nxt    = (result == ZERO_BYTE);
            zero_we_nxt = 1'b1;
          end
          if (is_skip && result == ZERO_BYTE) begin
            state_nxt = ST_FLUSH;
          end
        end
      end
      // a single bubble; the fetch stage simply moves on after it
      ST_FLUSH: state_nxt = ST_RUN;
      default:  state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r   <= ST_RUN;
      w_r       <= W_RESET;
      zero_r    <= 1'b0;
      file_we_r <= 1'b0;
      wdata_r   <= ZERO_BYTE;
      zero_we_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      w_r       <= w_nxt;
      zero_r    <= zero_nxt;
      file_we_r <= file_we_nxt;
      wdata_r   <= wdata_nxt;
      zero_we_r <= zero_we_nxt;
    end
  end

  assign file_we    = file_we_r;
  assign file_wdata = wdata_r;
  assign w_out      = w_r;
  assign zero_out   = zero_r;
  assign zero_we    = zero_we_r;

  property p_compl_value;
    @(posedge clk) disable iff (rst)
      exec && op_class == OP_COMPL && dest_file |=> file_we && file_wdata == ~$past(file_rdata);
  endproperty
  a_compl_value: assert property (p_compl_value) else $error("complement wrong");

  property p_compl_to_w;
    @(posedge clk) disable iff (rst)
      exec && op_class == OP_COMPL && !dest_file |=> !file_we && w_out == ~$past(file_rdata);
  endproperty
  a_compl_to_w: assert property (p_compl_to_w) else $error("complement to w wrong");

  property p_minus_value;
    @(posedge clk) disable iff (rst)
      exec && is_skip && dest_file |=> file_we && file_wdata == $past(file_rdata) - 8'h01;
  endproperty
  a_minus_value: assert property (p_minus_value) else $error("decrement wrong");

  property p_skip_to_w;
    @(posedge clk) disable iff (rst)
      exec && is_skip && !dest_file |=> !file_we && w_out == $past(file_rdata) - 8'h01;
  endproperty
  a_skip_to_w: assert property (p_skip_to_w) else $error("skip dest wrong");

  property p_skip_flush;
    @(posedge clk) disable iff (rst)
      exec && is_skip && file_rdata == 8'h01 |=> flush ##1 !flush;
  endproperty
  a_skip_flush: assert property (p_skip_flush) else $error("skip flush wrong");

  property p_no_skip;
    @(posedge clk) disable iff (rst)
      exec && !(is_skip && file_rdata == 8'h01) |=> !flush;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("spurious flush");

  property p_zero_flag;
    @(posedge clk) disable iff (rst)
      exec && !is_skip |=> zero_we &&
        zero_out == ($past(op_class == OP_COMPL) ? ($past(file_rdata) == 8'hff)
                                                  : ($past(file_rdata) == 8'h01));
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_skip_no_status;
    @(posedge clk) disable iff (rst)
      exec && is_skip |=> !zero_we && $stable(zero_out);
  endproperty
  a_skip_no_status: assert property (p_skip_no_status) else $error("skip touched status");

  property p_dec_value;
    @(posedge clk) disable iff (rst)
      exec && !is_skip && op_class == OP_MINUS && dest_file |=>
        file_we && file_wdata == $past(file_rdata) - 8'h01;
  endproperty
  a_dec_value: assert property (p_dec_value) else $error("plain decrement wrong");

  property p_dec_to_w;
    @(posedge clk) disable iff (rst)
      exec && !is_skip && op_class == OP_MINUS && !dest_file |=>
        !file_we && w_out == $past(file_rdata) - 8'h01;
  endproperty
  a_dec_to_w: assert property (p_dec_to_w) else $error("plain decrement to w wrong");

  property p_w_hold;
    @(posedge clk) disable iff (rst)
      exec && dest_file |=> $stable(w_out);
  endproperty
  a_w_hold: assert property (p_w_hold) else $error("w changed on register write");

  property p_flush_one;
    @(posedge clk) disable iff (rst)
      flush |=> !flush;
  endproperty
  a_flush_one: assert property (p_flush_one) else $error("flush longer than one cycle");

  property p_flush_refuse;
    @(posedge clk) disable iff (rst)
      flush |=> !file_we && !zero_we && $stable(w_out) && $stable(zero_out);
  endproperty
  a_flush_refuse: assert property (p_flush_refuse) else $error("word ran in flush");

  property p_idle_quiet;
    @(posedge clk) disable iff (rst)
      !insn_taken |=> !file_we && !zero_we && $stable(w_out) && $stable(zero_out);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("state changed while idle");

  property p_unrec_refused;
    @(posedge clk) disable iff (rst)
      insn_valid && insn[11:6] != 6'h09 && insn[11:6] != 6'h03 && insn[11:6] != 6'h0b
        |-> !insn_taken;
  endproperty
  a_unrec_refused: assert property (p_unrec_refused) else $error("foreign word taken");

  property p_known_taken;
    @(posedge clk) disable iff (rst)
      insn_valid && !flush &&
        (insn[11:6] == 6'h09 || insn[11:6] == 6'h03 || insn[11:6] == 6'h0b)
        |-> insn_taken;
  endproperty
  a_known_taken: assert property (p_known_taken) else $error("known word not taken");
endmodule // complement_decrement_skip_exec
`default_nettype wire

// ===== core/op_decode.sv
`timescale 1ns/100ps
`default_nettype none
module op_decode (
  input  wire logic [11:0]         insn,
  output var cds_pkg::op_class_e   op_class,
  output logic                     is_skip,
  output logic                     dest_file,
  output logic [4:0]               addr
);
  import cds_pkg::*;

  logic [5:0] opc;

  assign opc       = insn[INSN_W-1:OPC_LSB];
  assign dest_file = insn[DEST_BIT];
  assign addr      = insn[ADDR_W-1:0];

  always_comb begin
    op_class = OP_NONE;
    is_skip  = 1'b0;
    case (opc)
      OPC_COMPL:    op_class = OP_COMPL;
      OPC_MINUS:    op_class = OP_MINUS;
      OPC_MINUS_SK: begin
        op_class = OP_MINUS;
        is_skip  = 1'b1;
      end
      default:      op_class = OP_NONE;
    endcase
  end
endmodule // op_decode
`default_nettype wire

// ===== verif/regfile_model.sv
`timescale 1ns/100ps
`default_nettype none
module regfile_model (
  input  wire logic       clk,
  input  wire logic [4:0] file_addr,
  input  wire logic       file_we,
  input  wire logic [7:0] file_wdata,
  output logic      [7:0] file_rdata
);
  logic [7:0] mem [32];
  logic [4:0] addr_r;
  assign file_rdata = mem[file_addr];
  // write-back lands a cycle after the read, so keep last cycle's address
  always @(posedge clk) begin
    addr_r <= file_addr;
    if (file_we) mem[addr_r] <= file_wdata;
  end
endmodule // regfile_model
`default_nettype wire

// ===== verif/tb_complement_decrement_skip_exec.sv
`timescale 1ns/100ps
`default_nettype none
module tb_complement_decrement_skip_exec;
  import cds_pkg::*;
  localparam logic [5:0] UNREC = 6'h0a;
  logic        clk = 0, rst = 1, insn_valid = 0, d;
  logic [11:0] insn = 12'h000;
  logic [7:0]  file_rdata, file_wdata, w_out, v, res, w_exp;
  logic [4:0]  file_addr, a;
  logic [5:0]  opc;
  logic        file_we, zero_out, zero_we, flush, insn_taken, busy, exp_fl, z_exp, wr;
  int          n_fail = 0, comparisons = 0;
  complement_decrement_skip_exec dut (.clk(clk), .rst(rst), .insn_valid(insn_valid),
    .insn(insn), .file_rdata(file_rdata), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .w_out(w_out), .zero_out(zero_out), .zero_we(zero_we),
    .flush(flush), .busy(busy), .insn_taken(insn_taken));
  regfile_model rf (.clk(clk), .file_addr(file_addr), .file_we(file_we),
    .file_wdata(file_wdata), .file_rdata(file_rdata));
  initial forever #50 clk = ~clk;
  function automatic logic [7:0] exp_res(logic [5:0] o, logic [7:0] x);
    return (o == OPC_COMPL) ? ~x : x - ONE_BYTE;
  endfunction
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_reset;
    chk("w_out", W_RESET, w_out);
    chk("zero", 8'h00, {7'h00, zero_out});
    chk("file_we", 8'h00, {7'h00, file_we});
    chk("zero_we", 8'h00, {7'h00, zero_we});
    chk("flush", 8'h00, {7'h00, flush});
    chk("busy", 8'h00, {7'h00, busy});
  endtask
  task automatic print_verdict;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h723076c3));
    w_exp = W_RESET;
    z_exp = 1'b0;
    repeat (4) @(negedge clk);
    chk_reset();
    rst = 0;
    // first twelve cover wrap, zero and skip corners for every opcode
    for (int i = 0; i < 80; i++) begin
      if (i == 40) begin
        // a mid-run reset must clear accumulator and flag again
        rst = 1;
        repeat (2) @(negedge clk);
        chk_reset();
        rst = 0;
        w_exp = W_RESET;
        z_exp = 1'b0;
      end
      opc = (i % 4 == 0) ? OPC_COMPL : (i % 4 == 1) ? OPC_MINUS :
            (i % 4 == 2) ? OPC_MINUS_SK : UNREC;
      v = (i < 4) ? 8'h01 : (i < 8) ? 8'h00 : (i < 12) ? 8'hff : 8'($urandom);
      d = 1'($urandom);
      a = 5'($urandom);
      rf.mem[a] = v;
      res = exp_res(opc, v);
      exp_fl = opc == OPC_MINUS_SK && res == ZERO_BYTE;
      wr = opc != UNREC && d;
      insn = {opc, d, a};
      insn_valid = 1;
      #1 chk("taken", {7'h00, opc != UNREC}, {7'h00, insn_taken});
      @(negedge clk);
      // the word is offered again during the bubble and must be refused
      insn_valid = exp_fl;
      if (opc != UNREC && !d) w_exp = res;
      if (opc == OPC_COMPL || opc == OPC_MINUS) z_exp = res == ZERO_BYTE;
      #1 chk("refused", 8'h00, {7'h00, insn_taken});
      chk("w_out", w_exp, w_out);
      chk("file_we", {7'h00, wr}, {7'h00, file_we});
      if (wr) chk("file_wdata", res, file_wdata);
      chk("zero_we", {7'h00, opc == OPC_COMPL || opc == OPC_MINUS}, {7'h00, zero_we});
      chk("zero", {7'h00, z_exp}, {7'h00, zero_out});
      chk("flush", {7'h00, exp_fl}, {7'h00, flush});
      chk("busy", {7'h00, exp_fl}, {7'h00, busy});
      @(negedge clk);
      insn_valid = 0;
      chk("flush_end", 8'h00, {7'h00, flush});
      chk("file", wr ? res : v, rf.mem[a]);
    end
    print_verdict();
  end
endmodule // tb_complement_decrement_skip_exec
`default_nettype wire
